/* File: logic/damf_pkg.sv */
// Package for the data address modifier and status flag block.
// Assumes a 7-bit data memory address space with system registers at the top.
package damf_pkg;
    // System register addresses within the data memory map
    localparam logic [6:0] ADDR_IDX_HIGH = 7'h7a;
    localparam logic [6:0] ADDR_IDX_MID = 7'h7b;
    localparam logic [6:0] ADDR_IDX_LOW = 7'h7c;
    localparam logic [6:0] ADDR_GP_PTR_HIGH = 7'h7d;
    localparam logic [6:0] ADDR_PSW_HIGH = 7'h7e;
    localparam logic [6:0] ADDR_PSW_LOW = 7'h7f;
    localparam logic [6:0] ADDR_GP_PTR_LOW = 7'h7d;
    // Field positions in the status high nibble (7eh)
    localparam int PSW_BCD_BIT = 0;
    // Field positions in the status low nibble (7fh)
    localparam int PSW_CMP_BIT = 3;
    localparam int PSW_CY_BIT = 2;
    localparam int PSW_Z_BIT = 1;
    localparam int PSW_IXE_BIT = 0;
    // Row pointer enable flag sits in bit 3 of the index high nibble
    localparam int ROW_PTR_EN_BIT = 3;
    // Reset values
    localparam logic [3:0] PSW_HIGH_RESET = 4'h0;
    localparam logic [3:0] PSW_LOW_RESET = 4'h0;
    localparam logic [10:0] IDX_RESET = 11'h000;
    localparam logic [2:0] GP_PTR_RESET = 3'h0;
    localparam logic [1:0] BANK_ZERO = 2'h0;
    // Index register and row pointer widths
    localparam int IDX_WIDTH = 11;
    localparam int ROW_PTR_WIDTH = 7;
    // Operation codes presented by the instruction decoder
    typedef enum logic [2:0] {
        DAMF_OP_NONE,
        DAMF_OP_ADD,
        DAMF_OP_SUB,
        DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY,
        DAMF_OP_SKIP_TEST,
        DAMF_OP_LOGIC
    } damf_op_t;
    // Address mode presented by the instruction decoder
    typedef enum logic [1:0] {
        DAMF_AM_DIRECT,
        DAMF_AM_IND_STORE,
        DAMF_AM_IND_LOAD,
        DAMF_AM_FIXED
    } damf_amode_t;
endpackage : damf_pkg

/* File: logic/damf_nibble_alu.sv */
// Four-bit adder and subtractor with decimal adjust.
// Assumes operands arrive from the same clock domain; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module damf_nibble_alu
(
    input wire logic [3:0] i_a,
    input wire logic [3:0] i_b,
    input wire logic i_carry_in,
    input wire logic i_subtract,
    input wire logic i_decimal,
    output logic [3:0] o_result,
    output logic o_carry
);
    logic [4:0] bin_sum;
    logic [4:0] bin_diff;
    logic [4:0] dec_sum;
    logic [4:0] dec_diff;
    logic sum_over;
    logic diff_under;

    // Binary forms, borrow shows as bit 4 of the difference
    assign bin_sum = {1'b0, i_a} + {1'b0, i_b} + {4'h0, i_carry_in};
    assign bin_diff = {1'b0, i_a} - {1'b0, i_b} - {4'h0, i_carry_in};
    // Decimal adjust: add or subtract six when out of the 0..9 range
    assign sum_over = (bin_sum > 5'h09);
    assign dec_sum = sum_over ? bin_sum + 5'h06 : bin_sum;
    assign diff_under = bin_diff[4];
    assign dec_diff = diff_under ? bin_diff - 5'h06 : bin_diff;
    // Decimal or binary arithmetic per the mode flag
    assign o_result = i_subtract ? (i_decimal ? dec_diff[3:0] : bin_diff[3:0])
                                 : (i_decimal ? dec_sum[3:0] : bin_sum[3:0]); // RULE17
    assign o_carry = i_subtract ? diff_under : (i_decimal ? sum_over : bin_sum[4]); // RULE13
endmodule : damf_nibble_alu
`default_nettype wire

/* File: logic/damf_core.sv */
// Real data address former and program status flags of the 4-bit CPU.
// Assumes the decoder presents one instruction per cycle with a one-cycle
// execute strobe, and that data memory is external and answers in-cycle.
//
// Overview of operation
// RULE1 - Both modifier flags clear: addresses pass through unchanged.
// RULE2 - Indirect store writes m to m's bank and row, column from r.
// RULE3 - Indirect load reads m's bank and row, column from r, into m.
// RULE4 - Row pointer enabled alone: indirect side bank and row from row pointer.
// RULE5 - Row pointer is seven bits shared with upper index register bits.
// RULE6 - Index enabled alone: OR direct address with index register.
// RULE7 - Index register is eleven bits over three nibbles.
// RULE8 - Pointer high part reads zero; low three bits select rows 0-7, bank zero.
// RULE9 - Status word holds decimal, compare, carry, zero, index enable at 7eh/7fh.
// RULE10 - Index modification only while index enable flag is set.
// RULE11 - Nonzero arithmetic result clears zero flag.
// RULE12 - Zero result sets zero flag; with compare set only if already set.
// RULE13 - Carry flag set on carry or borrow, else cleared.
// RULE14 - Rotate right through carry loads carry with register bit 0.
// RULE15 - Compare flag set suppresses arithmetic result write-back.
// RULE16 - Bit test skip instructions clear compare flag.
// RULE17 - Decimal flag selects decimal arithmetic, else binary.
// RULE18 - Status nibbles read and written as system registers in any bank.
`timescale 1ns/10ps
`default_nettype none
module damf_core
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_exec,
    input wire damf_pkg::damf_op_t i_op,
    input wire damf_pkg::damf_amode_t i_amode,
    input wire logic [1:0] i_bank,
    input wire logic [6:0] i_operand_m,
    input wire logic [3:0] i_operand_r,
    input wire logic [3:0] i_gp_value,
    input wire logic [3:0] i_mem_value,
    input wire logic i_sys_write,
    input wire logic [6:0] i_sys_addr,
    input wire logic [3:0] i_sys_wdata,
    output logic [8:0] o_direct_addr,
    output logic [8:0] o_indirect_addr,
    output logic [8:0] o_gp_addr,
    output logic [3:0] o_result,
    output logic o_result_write,
    output logic [3:0] o_sys_rdata,
    output logic o_carry_flag,
    output logic o_zero_flag,
    output logic o_compare_flag,
    output logic o_decimal_flag,
    output logic o_index_enable_flag,
    output logic o_row_pointer_enable_flag
);
    logic [10:0] index_register;
    logic row_pointer_enable_flag;
    logic [2:0] gp_pointer_low_part;
    logic [3:0] psw_high;
    logic [3:0] psw_low;
    logic [3:0] next_psw_low;
    logic [3:0] alu_result;
    logic alu_carry;
    logic is_arith;
    logic result_zero;
    logic next_zero;
    logic [6:0] row_address_pointer;
    logic [8:0] direct_full;
    logic [8:0] index_ored;
    logic [8:0] next_direct;
    logic [8:0] next_indirect;
    logic [8:0] next_gp;
    logic index_on;
    logic row_ptr_on;
    logic ind_transfer;
    logic [3:0] next_result;
    logic [3:0] next_rdata;
    logic flag_write;

    // Shared arithmetic nibble
    damf_nibble_alu u_alu
    (
        .i_a(i_mem_value),
        .i_b(i_gp_value),
        .i_carry_in(1'b0),
        .i_subtract(i_op == damf_pkg::DAMF_OP_SUB),
        .i_decimal(psw_high[damf_pkg::PSW_BCD_BIT]),
        .o_result(alu_result),
        .o_carry(alu_carry)
    );

    // Row pointer is the upper seven index bits, so no separate storage
    assign row_address_pointer = index_register[10:4]; // RULE5
    assign index_on = psw_low[damf_pkg::PSW_IXE_BIT]; // RULE10
    assign row_ptr_on = row_pointer_enable_flag;

    // Direct address: bank, row, column of operand m
    assign direct_full = {i_bank, i_operand_m};
    // Index modification is a bitwise OR, not an add, so no carries ripple
    // Index bit n lands on address bit n; bits above the two bank bits reach nothing
    assign index_ored = direct_full | index_register[8:0]; // RULE6 RULE7
    // Only fixed-address instructions are never modified; system register addresses in other modes are ORed too
    assign next_direct = (index_on && !row_ptr_on && i_amode != damf_pkg::DAMF_AM_FIXED)
                         ? index_ored : direct_full; // RULE6 RULE1
    // Only register-indirect transfers take the pointer's bank and row
    assign ind_transfer = (i_amode == damf_pkg::DAMF_AM_IND_STORE)
                          || (i_amode == damf_pkg::DAMF_AM_IND_LOAD); // RULE4
    // Indirect side: column from register r contents; pointer bits 4:3 are the bank
    assign next_indirect = (row_ptr_on && !index_on && ind_transfer)
                           ? {row_address_pointer[4:3], row_address_pointer[2:0], i_gp_value}
                           : {i_bank, i_operand_m[6:4], i_gp_value}; // RULE4 RULE2 RULE3
    // General-purpose register always in bank zero, row from low pointer part
    assign next_gp = {damf_pkg::BANK_ZERO, gp_pointer_low_part, i_operand_r}; // RULE8

    // Flag updates
    assign is_arith = i_exec && (i_op == damf_pkg::DAMF_OP_ADD || i_op == damf_pkg::DAMF_OP_SUB);
    assign result_zero = (alu_result == 4'h0);
    assign next_zero = result_zero && (!psw_low[damf_pkg::PSW_CMP_BIT]
                       || psw_low[damf_pkg::PSW_Z_BIT]); // RULE11 RULE12
    assign flag_write = i_sys_write && i_sys_addr == damf_pkg::ADDR_PSW_LOW;
    always_comb
    begin
        next_psw_low = psw_low;
        if (flag_write)
        begin
            next_psw_low = i_sys_wdata; // RULE18
        end
        if (is_arith)
        begin
            next_psw_low[damf_pkg::PSW_Z_BIT] = next_zero; // RULE11 RULE12
            next_psw_low[damf_pkg::PSW_CY_BIT] = alu_carry; // RULE13
        end
        else if (i_exec && i_op == damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY)
        begin
            next_psw_low[damf_pkg::PSW_CY_BIT] = i_gp_value[0]; // RULE14
        end
        else if (i_exec && i_op == damf_pkg::DAMF_OP_SKIP_TEST)
        begin
            next_psw_low[damf_pkg::PSW_CMP_BIT] = 1'b0; // RULE16
        end
    end

    // ROTATE_RIGHT_THROUGH_CARRY result: carry shifted into bit 3
    assign next_result = (i_op == damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY)
                         ? {psw_low[damf_pkg::PSW_CY_BIT], i_gp_value[3:1]} : alu_result;

    // System register readback; unused high bits read zero
    assign next_rdata = (i_sys_addr == damf_pkg::ADDR_PSW_HIGH) ? psw_high :
                        (i_sys_addr == damf_pkg::ADDR_PSW_LOW) ? psw_low :
                        (i_sys_addr == damf_pkg::ADDR_IDX_HIGH)
                            ? {row_pointer_enable_flag, index_register[10:8]} :
                        (i_sys_addr == damf_pkg::ADDR_IDX_MID) ? index_register[7:4] :
                        (i_sys_addr == damf_pkg::ADDR_IDX_LOW) ? index_register[3:0] :
                        (i_sys_addr == damf_pkg::ADDR_GP_PTR_LOW)
                            ? {1'b0, gp_pointer_low_part} : 4'h0; // RULE8 RULE18

    // Status word registers
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            psw_high <= damf_pkg::PSW_HIGH_RESET;
            psw_low <= damf_pkg::PSW_LOW_RESET;
        end
        else
        begin
            if (i_sys_write && i_sys_addr == damf_pkg::ADDR_PSW_HIGH)
            begin
                psw_high <= {3'h0, i_sys_wdata[damf_pkg::PSW_BCD_BIT]}; // RULE9 RULE18
            end
            psw_low <= next_psw_low; // RULE9
        end
    end

    // Index register nibbles and pointer enable
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            index_register <= damf_pkg::IDX_RESET;
            row_pointer_enable_flag <= 1'b0;
            gp_pointer_low_part <= damf_pkg::GP_PTR_RESET;
        end
        else if (i_sys_write)
        begin
            if (i_sys_addr == damf_pkg::ADDR_IDX_HIGH)
            begin
                row_pointer_enable_flag <= i_sys_wdata[damf_pkg::ROW_PTR_EN_BIT];
                index_register[10:8] <= i_sys_wdata[2:0]; // RULE7
            end
            else if (i_sys_addr == damf_pkg::ADDR_IDX_MID)
            begin
                index_register[7:4] <= i_sys_wdata; // RULE7
            end
            else if (i_sys_addr == damf_pkg::ADDR_IDX_LOW)
            begin
                index_register[3:0] <= i_sys_wdata; // RULE7
            end
            else if (i_sys_addr == damf_pkg::ADDR_GP_PTR_LOW)
            begin
                gp_pointer_low_part <= i_sys_wdata[2:0]; // RULE8
            end
        end
    end

    // Registered outputs
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_direct_addr <= 9'h000;
            o_indirect_addr <= 9'h000;
            o_gp_addr <= 9'h000;
            o_result <= 4'h0;
            o_result_write <= 1'b0;
            o_sys_rdata <= 4'h0;
        end
        else
        begin
            o_direct_addr <= next_direct;
            o_indirect_addr <= next_indirect;
            o_gp_addr <= next_gp;
            o_result <= next_result;
            o_result_write <= is_arith && !psw_low[damf_pkg::PSW_CMP_BIT]; // RULE15
            o_sys_rdata <= next_rdata;
        end
    end

    // Flag outputs mirror the status word and the row pointer enable flag
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_carry_flag <= 1'b0;
            o_zero_flag <= 1'b0;
            o_compare_flag <= 1'b0;
            o_decimal_flag <= 1'b0;
            o_index_enable_flag <= 1'b0;
            o_row_pointer_enable_flag <= 1'b0;
        end
        else
        begin
            o_carry_flag <= next_psw_low[damf_pkg::PSW_CY_BIT];
            o_zero_flag <= next_psw_low[damf_pkg::PSW_Z_BIT];
            o_compare_flag <= next_psw_low[damf_pkg::PSW_CMP_BIT];
            o_decimal_flag <= psw_high[damf_pkg::PSW_BCD_BIT];
            o_index_enable_flag <= next_psw_low[damf_pkg::PSW_IXE_BIT];
            o_row_pointer_enable_flag <= row_pointer_enable_flag;
        end
    end

    // Checks
    sequence arith_cmp_s;
        is_arith && psw_low[damf_pkg::PSW_CMP_BIT];
    endsequence
    no_writeback_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE15
        arith_cmp_s |=> !o_result_write) else $error("write-back while compare set");
    zero_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE11
        is_arith && !result_zero |=> !psw_low[damf_pkg::PSW_Z_BIT])
        else $error("zero flag not cleared");
    zero_set_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE12
        is_arith && result_zero && !psw_low[damf_pkg::PSW_CMP_BIT]
        |=> psw_low[damf_pkg::PSW_Z_BIT]) else $error("zero flag not set");
    carry_rotate_right_through_carry_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE14
        i_exec && i_op == damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY |=> o_carry_flag == $past(i_gp_value[0]))
        else $error("rotate carry wrong");
    cmp_clear_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE16
        i_exec && i_op == damf_pkg::DAMF_OP_SKIP_TEST |=> !o_compare_flag)
        else $error("compare flag not cleared");
    no_modify_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE1
        !index_on && !row_ptr_on |=> o_direct_addr == $past(direct_full))
        else $error("address modified");
    index_or_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE6
        index_on && !row_ptr_on && i_amode == damf_pkg::DAMF_AM_DIRECT
        |=> o_direct_addr == ($past(direct_full) | $past(index_register[8:0])))
        else $error("index OR wrong");
    gp_bank_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE8
        1'b1 |=> o_gp_addr[8:7] == 2'h0) else $error("register outside bank zero");
    row_ptr_a: assert property (@(posedge i_clock) disable iff (i_sys_rst) // RULE4
        row_ptr_on && !index_on && ind_transfer
        |=> o_indirect_addr[8:4] == $past(row_address_pointer[4:0]))
        else $error("indirect bank and row not from pointer");
endmodule : damf_core
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the real address former and status flags core.
// Assumes the core answers one cycle after the sampling edge, single clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic i_clock, i_sys_rst, i_exec, i_sys_write;
    damf_pkg::damf_op_t i_op;
    damf_pkg::damf_amode_t i_amode;
    logic [1:0] i_bank;
    logic [6:0] i_operand_m, i_sys_addr;
    logic [3:0] i_operand_r, i_gp_value, i_mem_value, i_sys_wdata;
    logic [8:0] o_direct_addr, o_indirect_addr, o_gp_addr;
    logic [3:0] o_result, o_sys_rdata;
    logic o_result_write, o_carry_flag, o_zero_flag, o_compare_flag;
    logic o_decimal_flag, o_index_enable_flag, o_row_pointer_enable_flag;
    int miscompares, total_checks, cycles, i;
    // Reference copy of the flags and pointers
    logic mz, mcy, mcmp, mbcd, mixe, mmpe;
    logic [10:0] midx;
    logic [2:0] mrp;
    logic [31:0] d;
    logic [3:0] g, v;
    damf_pkg::damf_op_t ops [4] = '{damf_pkg::DAMF_OP_ADD, damf_pkg::DAMF_OP_SUB,
        damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY, damf_pkg::DAMF_OP_SKIP_TEST};

    damf_core DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_exec(i_exec), .i_op(i_op),
        .i_amode(i_amode), .i_bank(i_bank), .i_operand_m(i_operand_m),
        .i_operand_r(i_operand_r), .i_gp_value(i_gp_value), .i_mem_value(i_mem_value),
        .i_sys_write(i_sys_write), .i_sys_addr(i_sys_addr), .i_sys_wdata(i_sys_wdata),
        .o_direct_addr(o_direct_addr), .o_indirect_addr(o_indirect_addr),
        .o_gp_addr(o_gp_addr), .o_result(o_result), .o_result_write(o_result_write),
        .o_sys_rdata(o_sys_rdata), .o_carry_flag(o_carry_flag), .o_zero_flag(o_zero_flag),
        .o_compare_flag(o_compare_flag), .o_decimal_flag(o_decimal_flag),
        .o_index_enable_flag(o_index_enable_flag),
        .o_row_pointer_enable_flag(o_row_pointer_enable_flag));

    // Free-running 125 MHz clock
    always #4 i_clock = ~i_clock;

    // Hang guard, far above the roughly 780 cycles the run needs
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // System register write, then one idle edge so lagging flags settle
    task automatic wr(input logic [6:0] a, input logic [3:0] val);
        @(posedge i_clock);
        i_sys_write <= 1'b1;
        i_sys_addr <= a;
        i_sys_wdata <= val;
        @(posedge i_clock);
        i_sys_write <= 1'b0;
        case (a)
            7'h7a: {mmpe, midx[10:8]} = val;
            7'h7b: midx[7:4] = val;
            7'h7c: midx[3:0] = val;
            7'h7d: mrp = val[2:0];
            7'h7e: mbcd = val[0];
            7'h7f: {mcmp, mcy, mz, mixe} = val;
            default: ;
        endcase
        @(posedge i_clock);
        #1;
        chk({o_decimal_flag, o_row_pointer_enable_flag}, {mbcd, mmpe});
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [3:0] exp);
        @(posedge i_clock);
        i_sys_addr <= a;
        @(posedge i_clock);
        #1;
        chk(o_sys_rdata, exp);
    endtask : rd

    // One executed instruction against the reference model
    task automatic ex(input damf_pkg::damf_op_t op, input damf_pkg::damf_amode_t am,
        input logic [1:0] bk, input logic [6:0] m, input logic [3:0] r,
        input logic [3:0] gp, input logic [3:0] mem);
        logic [8:0] da, ia;
        logic [3:0] res;
        logic wb;
        int s;
        da = {bk, m};
        ia = {bk, m[6:4], gp};
        if (mixe && !mmpe && am != damf_pkg::DAMF_AM_FIXED)
            da = da | midx[8:0];
        if (mmpe && !mixe && (am == damf_pkg::DAMF_AM_IND_STORE ||
            am == damf_pkg::DAMF_AM_IND_LOAD))
            ia = {midx[8:7], midx[6:4], gp}; // Pointer bits 4:3 give the bank
        wb = 1'b0;
        res = 4'h0;
        case (op)
            damf_pkg::DAMF_OP_ADD, damf_pkg::DAMF_OP_SUB:
            begin
                s = (op == damf_pkg::DAMF_OP_ADD) ? mem + gp : mem - gp;
                if (mbcd && s > 9)
                    s = s + 6;
                if (mbcd && s < 0)
                    s = s - 6;
                mcy = (s > 15) || (s < 0);
                res = s[3:0];
                wb = !mcmp;
                if (res != 4'h0)
                    mz = 1'b0;
                else if (!mcmp)
                    mz = 1'b1;
            end
            damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY:
            begin
                res = {mcy, gp[3:1]};
                mcy = gp[0];
            end
            damf_pkg::DAMF_OP_SKIP_TEST: mcmp = 1'b0;
            default: ;
        endcase
        @(posedge i_clock);
        i_exec <= 1'b1;
        i_op <= op;
        i_amode <= am;
        i_bank <= bk;
        i_operand_m <= m;
        i_operand_r <= r;
        i_gp_value <= gp;
        i_mem_value <= mem;
        @(posedge i_clock);
        i_exec <= 1'b0;
        #1;
        chk(o_direct_addr, da);
        if (!(mixe && !mmpe))
            chk(o_indirect_addr, ia);
        chk(o_gp_addr, {2'b00, mrp, r});
        if (op inside {damf_pkg::DAMF_OP_ADD, damf_pkg::DAMF_OP_SUB, damf_pkg::DAMF_OP_ROTATE_RIGHT_THROUGH_CARRY})
            chk(o_result, res);
        chk(o_result_write, wb);
        if (op != damf_pkg::DAMF_OP_LOGIC)
            chk({o_compare_flag, o_carry_flag, o_zero_flag, o_index_enable_flag},
                {mcmp, mcy, mz, mixe});
    endtask : ex

    // Main sequence
    initial
    begin
        {i_clock, i_exec, i_sys_write, i_bank, i_operand_m, i_sys_addr} = '0;
        {i_operand_r, i_gp_value, i_mem_value, i_sys_wdata} = '0;
        {mz, mcy, mcmp, mbcd, mixe, mmpe, midx, mrp} = '0;
        i_op = damf_pkg::DAMF_OP_NONE;
        i_amode = damf_pkg::DAMF_AM_DIRECT;
        i_sys_rst = 1'b1;
        void'($urandom(32'h647c));
        repeat (16) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        rd(7'h7f, 4'h0);
        rd(7'h7e, 4'h0);
        // Every operation code once, address modes cycling through all four, unmodified
        for (i = 0; i < 6; i++)
            ex(damf_pkg::damf_op_t'(i), damf_pkg::damf_amode_t'(i % 4), 2'(i % 3),
                7'h34, 4'(i), 4'h8, 4'h5);
        wr(7'h7d, 4'hf);
        rd(7'h7d, 4'h7);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_DIRECT, 2'b01, 7'h05, 4'h9, 4'h0, 4'h0);
        // Index modification with a small and then random index
        wr(7'h7c, 4'h2);
        wr(7'h7f, 4'h1);
        ex(damf_pkg::DAMF_OP_ADD, damf_pkg::DAMF_AM_DIRECT, 2'b00, 7'h11, 4'h3, 4'h1, 4'h2);
        for (i = 0; i < 12; i++)
        begin
            d = $urandom;
            wr(7'h7b, d[3:0]);
            wr(7'h7c, d[7:4]);
            ex(damf_pkg::DAMF_OP_NONE, damf_pkg::damf_amode_t'(d[9:8]), 2'(d[11:10] % 3),
                7'(d[18:12] % 7'h74), d[23:20], d[27:24], 4'h0);
        end
        // Upper index bits must reach the bank bits, not the row
        wr(7'h7a, 4'h3);
        rd(7'h7a, 4'h3);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_DIRECT, 2'b00, 7'h11, 4'h0, 4'h0, 4'h0);
        wr(7'h7f, 4'h0);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_DIRECT, 2'b10, 7'h21, 4'h0, 4'h0, 4'h0);
        // Row pointer alone, then both modifiers set together
        wr(7'h7b, 4'h5);
        wr(7'h7a, 4'h8);
        rd(7'h7b, 4'h5);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_IND_STORE, 2'b00, 7'h34, 4'h5, 4'h8, 4'h0);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_IND_LOAD, 2'b01, 7'h3a, 4'hb, 4'he, 4'h0);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_DIRECT, 2'b00, 7'h3a, 4'hb, 4'he, 4'h0);
        wr(7'h7f, 4'h1);
        ex(damf_pkg::DAMF_OP_NONE, damf_pkg::DAMF_AM_IND_STORE, 2'b00, 7'h34, 4'h5, 4'h8, 4'h0);
        wr(7'h7a, 4'h0);
        wr(7'h7f, 4'h0);
        // Random arithmetic in both number modes and with compare set
        for (i = 0; i < 60; i++)
        begin
            d = $urandom;
            wr(7'h7e, {3'b000, d[0]});
            wr(7'h7f, {d[1], d[2], d[3], 1'b0});
            g = mbcd ? 4'(d[11:8] % 10) : d[11:8];
            v = mbcd ? 4'(d[15:12] % 10) : d[15:12];
            ex(ops[d[5:4]], damf_pkg::DAMF_AM_DIRECT, 2'b00, 7'h20, 4'h1, g, v);
            rd(7'h7f, {mcmp, mcy, mz, mixe});
        end
        close_out();
    end
endmodule : tb
`default_nettype wire
